// *** rtl/write_guard_consts.vh ***
/*
 * constants of the write guard and addressing block: command codes, register
 * reset values, protection codes and address offset table.
 * assumes it is included by its bare name from files under rtl/.
 */
`ifndef WRITE_GUARD_CONSTS_VH
`define WRITE_GUARD_CONSTS_VH

// command codes
`define CMD_PAGE           8'h00
`define CMD_OPERATION      8'h01
`define CMD_ON_OFF_CONFIG  8'h02
`define CMD_CLEAR_FAULTS   8'h03
`define CMD_WRITE_GUARD    8'h10
`define CMD_STORE_ALL      8'h15
`define CMD_BCAST_MASK     8'hE4
`define CMD_ADDR_BASE      8'hE6
`define CMD_NV_UNLOCK      8'hF0

// protection codes held in write_guard_level
`define GUARD_CODE_NONE    8'h00
`define GUARD_CODE_LVL2    8'h40
`define GUARD_CODE_LVL1    8'h80

// resolved protection levels
`define LEVEL_NONE         2'h0
`define LEVEL_ONE          2'h1
`define LEVEL_TWO          2'h2

// page values
`define PAGE_BCAST         8'hFF
`define PAGE_LAST_CH       8'h03

// reset values
`define RST_PAGE           8'h00
`define RST_GUARD_LEVEL    8'h00
`define RST_BCAST_MASK     4'hF
`define RST_ADDR_BASE      7'h5C

// register field widths
`define BCAST_MASK_W       4
`define ADDR_BASE_W        7

// address offset chosen by {addr_sel_in1, addr_sel_in0}
`define ADDR_OFS_SEL00     4'h0
`define ADDR_OFS_SEL01     4'h1
`define ADDR_OFS_SEL10     4'h4
`define ADDR_OFS_SEL11     4'h2

`endif

// *** rtl/guard_permit.v ***
/*
 * combinational check of whether a write to a command is permitted
 * at a given resolved protection level.
 * assumes the level is resolved by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "write_guard_consts.vh"

module guard_permit
(
    input  wire [1:0] level,
    input  wire [7:0] cmd,
    output wire       permit
);

    // commands open at level one
    function lvl1_open;
        input [7:0] c;
        begin
            lvl1_open = (c == `CMD_WRITE_GUARD) || (c == `CMD_PAGE) ||
                        (c == `CMD_NV_UNLOCK) || (c == `CMD_STORE_ALL);
        end
    endfunction

    // commands open at level two
    function lvl2_open;
        input [7:0] c;
        begin
            lvl2_open = lvl1_open(c) || (c == `CMD_OPERATION) ||
                        (c == `CMD_BCAST_MASK) || (c == `CMD_CLEAR_FAULTS);
        end
    endfunction

    assign permit = (level == `LEVEL_ONE) ? lvl1_open(cmd) :
                    (level == `LEVEL_TWO) ? lvl2_open(cmd) :
                    1'b1;

endmodule // guard_permit

`default_nettype wire

// *** rtl/bus_address_gen.v ***
/*
 * forms the 7-bit bus slave address from the base and the select inputs.
 * assumes select inputs are static or synchronous to the caller's clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "write_guard_consts.vh"

module bus_address_gen
(
    input  wire [6:0] base,
    input  wire       sel0,
    input  wire       sel1,
    output wire [6:0] dev_addr
);

    // offset lookup, range 0 to 4
    function [3:0] sel_offset;
        input [1:0] s;
        begin
            case (s)
                2'b00:   sel_offset = `ADDR_OFS_SEL00;
                2'b01:   sel_offset = `ADDR_OFS_SEL01;
                2'b10:   sel_offset = `ADDR_OFS_SEL10;
                default: sel_offset = `ADDR_OFS_SEL11;
            endcase
        end
    endfunction

    wire [3:0] ofs;

    assign ofs      = sel_offset({sel1, sel0});
    assign dev_addr = base + {3'b000, ofs};

endmodule // bus_address_gen

`default_nettype wire

// *** rtl/pmbus_write_guard_addressing.v ***
/*
 * write guard, broadcast channel mask and bus address forming for a
 * four-channel power manager command slave.
 * assumes a serial slave engine in front that decodes address bytes and
 * command transactions into single-cycle requests, and command storage
 * behind that takes forwarded accesses to commands not held here.
 */
//
// Behaviour
// - reads of supported commands allowed at any level
// - nonvolatile contents readable at every protection level
// - level one blocks all but four commands
// - level two adds operation, mask, clear faults
// - zero code with pin low opens all writes; host writes codes
// - protect pin high requests level two
// - effective level is the more restrictive one
// - four mask bits gate broadcast page accesses
// - mask zero ignores broadcast, one responds fully
// - mask upper four bits read zero
// - address is base plus offset zero to four
// - acknowledge only own computed address
// - both selects high give offset two
// - base address resets to 0x5C
// - base bits six to zero writable
// - base bit seven reads zero
// - broadcast page writes limited, others fault
// - paged read at broadcast page faults
// - broadcast mask resets all channels enabled
// - protection register resets to none
`timescale 1ns/1ps
`default_nettype none
`include "write_guard_consts.vh"

module pmbus_write_guard_addressing
#(
    parameter NUM_CH = 4
)
(
    input  wire              sys_clk,
    input  wire              nrst,
    input  wire              wp_pin,
    input  wire              addr_sel_in0,
    input  wire              addr_sel_in1,
    input  wire              addr_valid,
    input  wire [6:0]        addr_byte,
    input  wire              req_valid,
    input  wire              req_write,
    input  wire [7:0]        req_cmd,
    input  wire [7:0]        req_wdata,
    input  wire              req_paged,
    output reg               addr_ack,
    output reg  [6:0]        dev_addr,
    output reg               rsp_valid,
    output reg               rsp_ok,
    output reg               rsp_local,
    output reg  [7:0]        rsp_rdata,
    output reg               fwd_valid,
    output reg               fwd_write,
    output reg  [7:0]        fwd_cmd,
    output reg  [7:0]        fwd_wdata,
    output reg  [NUM_CH-1:0] fwd_ch,
    output reg  [1:0]        prot_level,
    output reg  [7:0]        page_out,
    output reg               comm_fault_flag
);

    // held registers
    reg  [7:0]        page_reg;
    reg  [7:0]        guard_level_reg;
    reg  [3:0]        bcast_mask_reg;
    reg  [6:0]        addr_base_reg;

    reg  [7:0]        page_next;
    reg  [7:0]        guard_level_next;
    reg  [3:0]        bcast_mask_next;
    reg  [6:0]        addr_base_next;
    reg               fault_next;

    reg  [1:0]        level_now;
    reg               is_local;
    reg               bcast_page;
    reg               bcast_cmd_ok;
    reg               accept;
    reg               fault_set;
    reg               fault_clr;
    reg  [7:0]        local_rdata;
    reg  [NUM_CH-1:0] ch_sel;

    wire              permit;
    wire [6:0]        addr_calc;
    wire              bcast_en_ch0;
    wire              bcast_en_ch1;
    wire              bcast_en_ch2;
    wire              bcast_en_ch3;
    wire [3:0]        bcast_en;

    // resolve the protection level from register and pin
    function [1:0] resolve_level;
        input [7:0] code;
        input       pin;
        begin
            if (code == `GUARD_CODE_LVL1)
                resolve_level = `LEVEL_ONE;
            else if (pin || (code == `GUARD_CODE_LVL2))
                resolve_level = `LEVEL_TWO;
            else
                resolve_level = `LEVEL_NONE;
        end
    endfunction

    // commands that may be written with the broadcast page
    function bcast_allowed;
        input [7:0] c;
        begin
            bcast_allowed = (c == `CMD_CLEAR_FAULTS) ||
                            (c == `CMD_OPERATION) ||
                            (c == `CMD_ON_OFF_CONFIG);
        end
    endfunction

    // only defined protection codes are stored
    function guard_code_ok;
        input [7:0] v;
        begin
            guard_code_ok = (v == `GUARD_CODE_NONE) ||
                            (v == `GUARD_CODE_LVL1) ||
                            (v == `GUARD_CODE_LVL2);
        end
    endfunction

    // commands whose registers are held in this block
    function held_local;
        input [7:0] c;
        begin
            held_local = (c == `CMD_PAGE) ||
                         (c == `CMD_WRITE_GUARD) ||
                         (c == `CMD_BCAST_MASK) ||
                         (c == `CMD_ADDR_BASE);
        end
    endfunction

    // per-channel broadcast enables of the mask
    assign bcast_en_ch0 = bcast_mask_reg[0];
    assign bcast_en_ch1 = bcast_mask_reg[1];
    assign bcast_en_ch2 = bcast_mask_reg[2];
    assign bcast_en_ch3 = bcast_mask_reg[3];
    assign bcast_en     = {bcast_en_ch3, bcast_en_ch2, bcast_en_ch1, bcast_en_ch0};

    guard_permit u_permit
    (
        .level  (level_now),
        .cmd    (req_cmd),
        .permit (permit)
    );

    bus_address_gen u_addr
    (
        .base     (addr_base_reg),
        .sel0     (addr_sel_in0),
        .sel1     (addr_sel_in1),
        .dev_addr (addr_calc)
    );

    // request decode
    always @*
    begin
        level_now    = resolve_level(guard_level_reg, wp_pin);
        is_local     = held_local(req_cmd);
        bcast_page   = (page_reg == `PAGE_BCAST);
        bcast_cmd_ok = bcast_allowed(req_cmd);
        accept       = 1'b0;
        fault_set    = 1'b0;
        fault_clr    = 1'b0;
        ch_sel       = {NUM_CH{1'b0}};
        local_rdata  = 8'h00;

        // channel targets of the access
        if (bcast_page)
            ch_sel = bcast_en[NUM_CH-1:0];
        else if (page_reg <= `PAGE_LAST_CH)
            ch_sel[page_reg[1:0]] = 1'b1;

        // read data of the held registers
        case (req_cmd)
            `CMD_PAGE:        local_rdata = page_reg;
            `CMD_WRITE_GUARD: local_rdata = guard_level_reg;
            `CMD_BCAST_MASK:  local_rdata = {4'h0, bcast_mask_reg};
            `CMD_ADDR_BASE:   local_rdata = {1'b0, addr_base_reg};
            default:          local_rdata = 8'h00;
        endcase

        if (req_valid)
        begin
            if (!req_write)
            begin
                // reads never depend on the protection level
                if (req_paged && bcast_page)
                    fault_set = 1'b1;
                else
                    accept = 1'b1;
            end
            else if (!permit)
                fault_set = 1'b1;
            else if (req_paged && bcast_page && !bcast_cmd_ok)
                fault_set = 1'b1;
            else if (req_cmd == `CMD_WRITE_GUARD && !guard_code_ok(req_wdata))
                fault_set = 1'b1;
            else
            begin
                accept    = 1'b1;
                fault_clr = (req_cmd == `CMD_CLEAR_FAULTS);
            end
        end
    end

    // register updates
    always @*
    begin
        page_next        = page_reg;
        guard_level_next = guard_level_reg;
        bcast_mask_next  = bcast_mask_reg;
        addr_base_next   = addr_base_reg;
        if (accept && req_write)
        begin
            case (req_cmd)
                `CMD_PAGE:
                    page_next = req_wdata;
                `CMD_WRITE_GUARD:
                    guard_level_next = req_wdata;
                `CMD_BCAST_MASK:
                    bcast_mask_next = req_wdata[3:0];
                `CMD_ADDR_BASE:
                    addr_base_next = req_wdata[6:0];
                default:
                    page_next = page_reg;
            endcase
        end
        // a fault arriving with a clear still sets the flag
        fault_next = (comm_fault_flag & ~fault_clr) | fault_set;
    end

    // page and protection registers
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            page_reg        <= `RST_PAGE;
            guard_level_reg <= `RST_GUARD_LEVEL;
        end
        else
        begin
            page_reg        <= page_next;
            guard_level_reg <= guard_level_next;
        end
    end

    // broadcast mask and address base registers
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bcast_mask_reg  <= `RST_BCAST_MASK;
            addr_base_reg   <= `RST_ADDR_BASE;
        end
        else
        begin
            bcast_mask_reg  <= bcast_mask_next;
            addr_base_reg   <= addr_base_next;
        end
    end

    // sticky communication fault flag
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            comm_fault_flag <= 1'b0;
        else
            comm_fault_flag <= fault_next;
    end

    // address matching
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_ack <= 1'b0;
            dev_addr <= `RST_ADDR_BASE;
        end
        else
        begin
            addr_ack <= addr_valid && (addr_byte == addr_calc);
            dev_addr <= addr_calc;
        end
    end

    // visible protection level and page
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prot_level <= `LEVEL_NONE;
            page_out   <= `RST_PAGE;
        end
        else
        begin
            prot_level <= level_now;
            page_out   <= page_next;
        end
    end

    // answer to the request
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp_ok    <= 1'b0;
            rsp_local <= 1'b0;
            rsp_rdata <= 8'h00;
        end
        else
        begin
            rsp_valid <= req_valid;
            rsp_ok    <= accept;
            rsp_local <= req_valid && is_local;
            rsp_rdata <= (req_valid && !req_write && is_local) ? local_rdata : 8'h00;
        end
    end

    // forward to command storage
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fwd_valid <= 1'b0;
            fwd_write <= 1'b0;
            fwd_cmd   <= 8'h00;
            fwd_wdata <= 8'h00;
            fwd_ch    <= {NUM_CH{1'b0}};
        end
        else
        begin
            fwd_valid <= accept && !is_local;
            fwd_write <= req_valid && req_write;
            fwd_cmd   <= req_valid ? req_cmd : fwd_cmd;
            fwd_wdata <= req_valid ? req_wdata : fwd_wdata;
            fwd_ch    <= (accept && req_paged) ? ch_sel : {NUM_CH{1'b0}};
        end
    end

endmodule // pmbus_write_guard_addressing

`default_nettype wire

// *** tb/write_guard_sva.sv ***
/* checker of the write guard block, bound to its top module.
   assumes the rtl constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "write_guard_consts.vh"
module write_guard_sva
#(
    parameter NUM_CH = 4
)
(
    input wire logic              sys_clk, nrst, wp_pin, req_valid, req_write, req_paged,
    input wire logic              addr_valid, addr_ack, rsp_valid, rsp_ok, rsp_local,
    input wire logic              fwd_valid, fwd_write, comm_fault_flag,
    input wire logic [7:0]        req_cmd, rsp_rdata, fwd_cmd, page_out,
    input wire logic [6:0]        addr_byte, dev_addr,
    input wire logic [1:0]        prot_level,
    input wire logic [NUM_CH-1:0] fwd_ch
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    refuse_flag_a:
        assert property (req_valid |=> rsp_valid && (rsp_ok || comm_fault_flag))
        else $error("refusal without fault flag");
    read_open_a:
        assert property (req_valid && !req_write && !req_paged |=> rsp_ok)
        else $error("read refused");
    base_guard_a:
        assert property (req_valid && req_write && !req_paged && req_cmd == `CMD_ADDR_BASE
            |=> rsp_ok == (prot_level == `LEVEL_NONE)) else $error("base write decision wrong");
    level_one_a:
        assert property (req_valid && req_write && req_cmd == `CMD_OPERATION
            |=> !(rsp_ok && prot_level == `LEVEL_ONE)) else $error("level one let write in");
    pin_level_a:
        assert property (wp_pin |=> prot_level != `LEVEL_NONE)
        else $error("pin high without protection");
    addr_match_a:
        assert property (addr_valid |=> addr_ack == ($past(addr_byte) == $past(dev_addr)))
        else $error("address answer wrong");
    bcast_read_a:
        assert property (req_valid && !req_write && req_paged && page_out == `PAGE_BCAST
            |=> !rsp_ok && comm_fault_flag) else $error("broadcast read not faulted");
    bcast_write_a:
        assert property (req_valid && req_write && req_paged && page_out == `PAGE_BCAST
            && (req_cmd == 8'h00 || req_cmd > `CMD_CLEAR_FAULTS) |=> !rsp_ok && !fwd_valid)
        else $error("broadcast write let through");
    page_target_a:
        assert property (req_valid && req_paged && page_out < 8'h04
            |=> !fwd_valid || fwd_ch == NUM_CH'(1) << $past(page_out[1:0]))
        else $error("page target wrong");
    mask_top_a:
        assert property (rsp_valid && rsp_local && !fwd_write && fwd_cmd == `CMD_BCAST_MASK
            |-> rsp_rdata[7:4] == 4'h0) else $error("mask upper bits set");
    base_top_a:
        assert property (rsp_valid && rsp_local && !fwd_write && fwd_cmd == `CMD_ADDR_BASE
            |-> !rsp_rdata[7]) else $error("base bit seven set");
endmodule // write_guard_sva
bind pmbus_write_guard_addressing write_guard_sva #(.NUM_CH(NUM_CH)) u_sva
(
    .sys_clk         (sys_clk),
    .nrst            (nrst),
    .wp_pin          (wp_pin),
    .req_valid       (req_valid),
    .req_write       (req_write),
    .req_paged       (req_paged),
    .addr_valid      (addr_valid),
    .addr_ack        (addr_ack),
    .rsp_valid       (rsp_valid),
    .rsp_ok          (rsp_ok),
    .rsp_local       (rsp_local),
    .fwd_valid       (fwd_valid),
    .fwd_write       (fwd_write),
    .comm_fault_flag (comm_fault_flag),
    .req_cmd         (req_cmd),
    .rsp_rdata       (rsp_rdata),
    .fwd_cmd         (fwd_cmd),
    .page_out        (page_out),
    .addr_byte       (addr_byte),
    .dev_addr        (dev_addr),
    .prot_level      (prot_level),
    .fwd_ch          (fwd_ch)
);
`default_nettype wire

// *** tb/host_model.sv ***
/* host side of the command port: presents requests, keeps the answers.
   assumes answers come one cycle after the request is taken. */
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    input  wire logic       sys_clk,
    input  wire logic       rsp_ok,
    input  wire logic [7:0] rsp_rdata,
    input  wire logic [3:0] fwd_ch,
    output var  logic       req_valid,
    output var  logic       req_write,
    output var  logic [7:0] req_cmd,
    output var  logic [7:0] req_wdata,
    output var  logic       req_paged
);
    logic       ok;
    logic [7:0] rd;
    logic [3:0] ch;
    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_cmd   = 8'h00;
        req_wdata = 8'h00;
        req_paged = 1'b0;
    end
    // callers hand only the three guard codes to the guard register
    task xfer(input logic w, input logic [7:0] c, input logic [7:0] d, input logic p);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_cmd   <= c;
        req_wdata <= d;
        req_paged <= p;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req_cmd   <= ~c;
        req_wdata <= ~d;
        #1;
        ok = rsp_ok;
        rd = rsp_rdata;
        ch = fwd_ch;
    endtask
endmodule // host_model
`default_nettype wire

// *** tb/pmbus_write_guard_addressing_bench.sv ***
/* bench of the write guard block: host model on the command port,
   pin and address stimulus here. assumes the rtl constants header. */
`timescale 1ns/1ps
`default_nettype none
`include "write_guard_consts.vh"
module pmbus_write_guard_addressing_bench;
    logic       sys_clk, nrst, wp_pin, addr_sel_in0, addr_sel_in1, addr_valid;
    logic       req_valid, req_write, req_paged, addr_ack, rsp_valid, rsp_ok, rsp_local;
    logic       fwd_valid, fwd_write, comm_fault_flag;
    logic [6:0] addr_byte, dev_addr;
    logic [7:0] req_cmd, req_wdata, rsp_rdata, fwd_cmd, fwd_wdata, page_out;
    logic [3:0] fwd_ch;
    logic [1:0] prot_level;
    int         errors, tests_run, cycles;

    pmbus_write_guard_addressing #(.NUM_CH(4)) u_dut (.*);
    host_model u_host (.*);

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errors = errors + 1;
            wrap_up();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task adr(input logic [6:0] a, input logic exp);
        @(posedge sys_clk);
        addr_valid <= 1'b1;
        addr_byte  <= a;
        @(posedge sys_clk);
        addr_valid <= 1'b0;
        addr_byte  <= ~a;
        #1 chk(addr_ack, exp);
    endtask

    task t_reset;
        u_host.xfer(0, `CMD_ADDR_BASE, 0, 0);
        chk(u_host.rd, 8'h5C);
        u_host.xfer(0, `CMD_BCAST_MASK, 0, 0);
        chk(u_host.rd, 8'h0F);
        chk({rsp_valid, rsp_local, fwd_valid}, 3'b110);
        chk(rsp_rdata, 8'h0F);
        u_host.xfer(0, `CMD_WRITE_GUARD, 0, 0);
        chk(u_host.rd, 8'h00);
        chk(dev_addr, 8'h5E);
        $display("reset values done");
    endtask

    task t_addr;
        logic [6:0] e;
        adr(7'h5E, 1);
        adr(7'h5F, 0);
        u_host.xfer(1, `CMD_ADDR_BASE, 8'hA0, 0);
        u_host.xfer(0, `CMD_ADDR_BASE, 0, 0);
        chk(u_host.rd, 8'h20);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk) {addr_sel_in1, addr_sel_in0} <= i[1:0];
            e = i == 0 ? `ADDR_OFS_SEL00 : i == 1 ? `ADDR_OFS_SEL01 : i == 2 ? `ADDR_OFS_SEL10 : `ADDR_OFS_SEL11;
            repeat (2) @(posedge sys_clk);
            #1 chk(dev_addr, 7'h20 + e);
        end
        adr(7'h22, 1);
        $display("address forming done");
    endtask

    task t_guard;
        logic [7:0] code, b;
        logic [1:0] lv;
        b = 8'h20;
        for (int k = 0; k < 6; k++)
        begin
            code = k < 2 ? `GUARD_CODE_NONE : k < 4 ? `GUARD_CODE_LVL2 : `GUARD_CODE_LVL1;
            lv = k > 3 ? `LEVEL_ONE : (k > 1 || k % 2) ? `LEVEL_TWO : `LEVEL_NONE;
            u_host.xfer(1, `CMD_WRITE_GUARD, code, 0);
            chk(u_host.ok, 1);
            @(posedge sys_clk) wp_pin <= k % 2;
            u_host.xfer(1, `CMD_ADDR_BASE, 8'h30 + k, 0);
            chk(u_host.ok, lv == `LEVEL_NONE);
            chk(prot_level, lv);
            chk(comm_fault_flag, lv != `LEVEL_NONE);
            if (lv == `LEVEL_NONE)
                b = 8'h30 + k;
            u_host.xfer(1, `CMD_OPERATION, 8'h80, 1);
            chk(u_host.ok, lv != `LEVEL_ONE);
            chk(fwd_valid, lv != `LEVEL_ONE);
            u_host.xfer(1, k[0] ? `CMD_NV_UNLOCK : `CMD_STORE_ALL, 8'h00, 0);
            chk(u_host.ok, 1);
            u_host.xfer(1, `CMD_BCAST_MASK, 8'h0F, 0);
            chk(u_host.ok, lv != `LEVEL_ONE);
            u_host.xfer(1, `CMD_PAGE, 8'h00, 0);
            chk(u_host.ok, 1);
            u_host.xfer(0, `CMD_ADDR_BASE, 0, 0);
            chk(u_host.rd, b);
            chk(u_host.ok, 1);
            @(posedge sys_clk) wp_pin <= 1'b0;
            u_host.xfer(1, `CMD_WRITE_GUARD, `GUARD_CODE_NONE, 0);
            u_host.xfer(1, `CMD_CLEAR_FAULTS, 0, 0);
            chk(comm_fault_flag, 0);
        end
        $display("protection levels done");
    endtask

    task t_bcast;
        u_host.xfer(1, `CMD_BCAST_MASK, 8'hF5, 0);
        u_host.xfer(0, `CMD_BCAST_MASK, 0, 0);
        chk(u_host.rd, 8'h05);
        u_host.xfer(1, `CMD_PAGE, `PAGE_BCAST, 0);
        chk(page_out, `PAGE_BCAST);
        u_host.xfer(1, `CMD_OPERATION, 8'h80, 1);
        chk(u_host.ch, 4'h5);
        chk({fwd_valid, fwd_write, rsp_local}, 3'b110);
        chk(fwd_cmd, `CMD_OPERATION);
        chk(fwd_wdata, 8'h80);
        u_host.xfer(1, `CMD_ON_OFF_CONFIG, 8'h1E, 1);
        chk({u_host.ok, u_host.ch}, 5'h15);
        u_host.xfer(1, 8'h21, 8'h01, 1);
        chk({u_host.ok, comm_fault_flag}, 2'b01);
        chk({fwd_valid, fwd_ch}, 5'h00);
        u_host.xfer(1, `CMD_CLEAR_FAULTS, 0, 0);
        u_host.xfer(0, 8'h21, 0, 1);
        chk({u_host.ok, comm_fault_flag}, 2'b01);
        u_host.xfer(1, `CMD_PAGE, 8'h02, 0);
        u_host.xfer(1, `CMD_OPERATION, 8'h80, 1);
        chk(u_host.ch, 4'h4);
        $display("broadcast mask done");
    endtask

    initial
    begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        wp_pin = 1'b0;
        addr_sel_in0 = 1'b1;
        addr_sel_in1 = 1'b1;
        addr_valid = 1'b0;
        addr_byte = 7'h00;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset;
        t_addr;
        t_guard;
        t_bcast;
        wrap_up;
    end
endmodule // pmbus_write_guard_addressing_bench
`default_nettype wire
